// File: rtl/psr_defs.svh
// Purpose: Constants of the processor-status register bank.
// Assumes: Register numbers are those used by the status instructions.
// Notes: Included by every module file of the bank.
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// ****************************************************************
// Register numbers
// ****************************************************************
`define PSR_NUM_VECTOR 8'h01
`define PSR_NUM_TILECTL 8'h02
`define PSR_NUM_BOOT 8'h03
`define PSR_NUM_SECURITY 8'h05
`define PSR_NUM_RINGCTL 8'h06
`define PSR_NUM_RING_TCELL 8'h07
`define PSR_NUM_RING_TWIRE 8'h08
`define PSR_NUM_RING_PCELL 8'h09
`define PSR_NUM_RING_PWIRE 8'h0A
`define PSR_NUM_RAMSIZE 8'h0C

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define PSR_VECTOR_WMASK 32'hFFFC_0000
`define PSR_TILECTL_WMASK 32'h03FF_FF30
`define PSR_SECURITY_WMASK 32'h8000_5FB1
`define PSR_RINGCTL_WMASK 32'h0000_0003
`define PSR_VECTOR_RST 32'h0000_0000
`define PSR_TILECTL_RST 32'h0000_0000
`define PSR_SECURITY_RST 32'h0000_0000
`define PSR_RINGCTL_RST 32'h0000_0000
`define PSR_RAM_SIZE 32'h0008_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define PSR_VEC_HI_MSB 31
`define PSR_VEC_HI_LSB 16
`define PSR_TXDLY_MSB 25
`define PSR_TXDLY_LSB 18
`define PSR_TXDIV_MSB 17
`define PSR_TXDIV_LSB 9
`define PSR_PORTEN_BIT 8
`define PSR_DYNDIV_BIT 5
`define PSR_DIVEN_BIT 4
`define PSR_SEC_LOCK_BIT 31
`define PSR_SEC_GDBG_BIT 14
`define PSR_SEC_OTPALL_BIT 12
`define PSR_SEC_SECT_MSB 11
`define PSR_SEC_SECT_LSB 8
`define PSR_SEC_REDUN_BIT 7
`define PSR_SEC_BOOTOTP_BIT 5
`define PSR_SEC_JTAGCFG_BIT 4
`define PSR_SEC_TAP_BIT 0
`define PSR_RING_CORE_BIT 1
`define PSR_RING_PERIPH_BIT 0
`define PSR_RING_W 16
`define PSR_TXDIV_W 9
`define PSR_TXDLY_W 8
`define PSR_BOOT_PROC_LSB 16
`define PSR_BOOT_OVR_BIT 8
`define PSR_BOOT_CORE1_BIT 5
`define PSR_BOOT_SKIPPOLL_BIT 4
`define PSR_BOOT_RAM_BIT 3
`define PSR_BOOT_JTAG_BIT 2
`define PSR_RAMSIZE_LOWMASK 32'hFFFF_FFFC

`endif

// File: rtl/psr_pkg.sv
// Purpose: Types shared by the processor-status register bank.
// Assumes: Constants come from psr_defs.svh.
// Notes: Request and answer travel as packed structs.
package psr_pkg;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] num;
      logic [31:0] wdata;
   } psr_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] rdata;
   } psr_rsp_t;

   typedef struct packed {
      logic bootOverride;
      logic core1Off;
      logic skipOtpPoll;
      logic bootFromRam;
      logic bootFromJtag;
   } psr_boot_t;

   typedef struct packed {
      logic globalDebugOff;
      logic jtagCfgBlock;
      logic debugTapOff;
      logic otpLockAll;
      logic [3:0] otpSectorLock;
      logic otpRedundancy;
      logic bootFromOtp;
   } psr_sec_t;

   typedef enum logic [1:0] {
      PSR_CAP_WAIT = 2'b00,
      PSR_CAP_DONE = 2'b01
   } psr_cap_t;

endpackage

// File: rtl/psr_ring_counter.sv
// Purpose: Counts rising edges of one free-running ring oscillator.
// Assumes: The oscillator output is asynchronous to clk.
// Notes: The count is deliberately kept through reset.
`timescale 1ns/1ns
`include "psr_defs.svh"
module psr_ring_counter
   import psr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic enable,
   input wire logic oscIn,
   // Count
   output logic [`PSR_RING_W-1:0] count
);

   logic syncA_r;
   logic syncB_r;
   logic syncC_r;
   // Powers up at zero; no reset clears it afterwards.
   logic [`PSR_RING_W-1:0] count_r = '0;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_r <= 1'b0;
         syncB_r <= 1'b0;
         syncC_r <= 1'b0;
      end
      else
      begin
         syncA_r <= oscIn;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end

   // No reset term: the count must outlive a system reset.
   always_ff @(posedge clk)
   begin
      if (enable && syncB_r && !syncC_r)
      begin
         count_r <= count_r + `PSR_RING_W'(1);
      end
   end

   assign count = count_r;

endmodule

// File: rtl/psr_status_regs.sv
// Purpose: Processor-status register bank of one tile.
// Assumes: Requests arrive on clk; answers follow one cycle later.
// Notes: Boot strap and mode-pin inputs are captured once after reset release.
`timescale 1ns/1ns
`include "psr_defs.svh"
module psr_status_regs
   import psr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Status instruction port
   input psr_req_t psReq,
   output psr_rsp_t psRsp,
   // Event vectoring
   input wire logic eventTake,
   input wire logic [15:0] eventVector,
   output logic [31:0] vectorAddr,
   output logic vectorAddrValid,
   // Tile control
   input wire logic allThreadsPaused,
   output logic rgmiiTxClk,
   output logic rgmiiTxLaunch,
   output logic rgmiiPortEn,
   output logic lowPowerDivOn,
   // Boot straps
   input wire logic [7:0] processorNumber,
   input wire logic [1:0] bootPllModePin,
   input psr_boot_t bootStrap,
   // Security word load
   input wire logic otpSecValid,
   input wire logic [31:0] otpSecWord,
   output psr_sec_t secCtl,
   // Ring oscillators
   input wire logic [3:0] ringOscPin,
   output logic [3:0] ringOscEn,
   output logic [`PSR_RING_W-1:0] ringCount [4]
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [31:0] vectorBase_r;
   logic [31:0] tileCtl_r;
   logic [31:0] security_r;
   logic [31:0] ringCtl_r;
   logic [31:0] bootStatus_r;
   logic [1:0] pllSyncA_r;
   logic [1:0] pllSyncB_r;
   logic [1:0] pllSyncC_r;
   logic [2:0] pllFill_r;
   psr_cap_t capState_r;
   psr_rsp_t psRsp_r;
   logic [31:0] vectorAddr_r;
   logic vectorAddrValid_r;
   logic lowPowerDivOn_r;
   logic [31:0] rdata_nxt;
   logic hit_nxt;
   logic secWrite;
   logic secRefused;
   logic [3:0] oscEnable;
   logic [`PSR_RING_W-1:0] ringCnt [4];

   assign secWrite = psReq.wr && psReq.num == `PSR_NUM_SECURITY;
   assign secRefused = secWrite && security_r[`PSR_SEC_LOCK_BIT];

   // ****************************************************************
   // Vector base and event address
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vectorBase_r <= `PSR_VECTOR_RST;
      end
      else if (psReq.wr && psReq.num == `PSR_NUM_VECTOR)
      begin
         vectorBase_r <= psReq.wdata & `PSR_VECTOR_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vectorAddr_r <= '0;
         vectorAddrValid_r <= 1'b0;
      end
      else
      begin
         vectorAddrValid_r <= eventTake;
         if (eventTake)
         begin
            vectorAddr_r <= {vectorBase_r[`PSR_VEC_HI_MSB:`PSR_VEC_HI_LSB],
                             eventVector};
         end
      end
   end

   // ****************************************************************
   // Tile control
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tileCtl_r <= `PSR_TILECTL_RST;
      end
      else if (psReq.wr && psReq.num == `PSR_NUM_TILECTL)
      begin
         tileCtl_r <= psReq.wdata & `PSR_TILECTL_WMASK;
      end
   end

   // Dynamic mode lets the divider act only while every thread waits.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lowPowerDivOn_r <= 1'b0;
      end
      else
      begin
         lowPowerDivOn_r <= tileCtl_r[`PSR_DIVEN_BIT] &&
            (!tileCtl_r[`PSR_DYNDIV_BIT] || allThreadsPaused);
      end
   end

   psr_txclk_div u_txclk
   (
      .clk(clk),
      .rst_n(rst_n),
      .enable(tileCtl_r[`PSR_PORTEN_BIT]),
      .divVal(tileCtl_r[`PSR_TXDIV_MSB:`PSR_TXDIV_LSB]),
      .dlyVal(tileCtl_r[`PSR_TXDLY_MSB:`PSR_TXDLY_LSB]),
      .txClk(rgmiiTxClk),
      .txLaunch(rgmiiTxLaunch)
   );

   // ****************************************************************
   // Boot status capture
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pllSyncA_r <= 2'h0;
         pllSyncB_r <= 2'h0;
         pllSyncC_r <= 2'h0;
         pllFill_r <= 3'h0;
      end
      else
      begin
         pllSyncA_r <= bootPllModePin;
         pllSyncB_r <= pllSyncA_r;
         pllSyncC_r <= pllSyncB_r;
         pllFill_r <= {pllFill_r[1:0], 1'b1};
      end
   end

   // The mode pins are taken once their synchroniser has settled.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capState_r <= PSR_CAP_WAIT;
         bootStatus_r <= '0;
      end
      else
      begin
         case (capState_r)
            PSR_CAP_WAIT:
            begin
               if (pllFill_r[2] && pllSyncB_r == pllSyncC_r)
               begin
                  bootStatus_r <= '0;
                  bootStatus_r[`PSR_BOOT_PROC_LSB +: 8] <=
                     processorNumber;
                  bootStatus_r[1:0] <= pllSyncC_r;
                  bootStatus_r[`PSR_BOOT_OVR_BIT] <=
                     bootStrap.bootOverride;
                  bootStatus_r[`PSR_BOOT_CORE1_BIT] <=
                     bootStrap.core1Off;
                  bootStatus_r[`PSR_BOOT_SKIPPOLL_BIT] <=
                     bootStrap.skipOtpPoll;
                  bootStatus_r[`PSR_BOOT_RAM_BIT] <=
                     bootStrap.bootFromRam;
                  bootStatus_r[`PSR_BOOT_JTAG_BIT] <=
                     bootStrap.bootFromJtag;
                  capState_r <= PSR_CAP_DONE;
               end
            end
            PSR_CAP_DONE:
            begin
               capState_r <= PSR_CAP_DONE;
            end
            default:
            begin
               capState_r <= PSR_CAP_WAIT;
            end
         endcase
      end
   end

   // ****************************************************************
   // Security configuration
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         security_r <= `PSR_SECURITY_RST;
      end
      else if (otpSecValid)
      begin
         security_r <= otpSecWord & `PSR_SECURITY_WMASK;
      end
      else if (secWrite && !secRefused)
      begin
         security_r <= psReq.wdata & `PSR_SECURITY_WMASK;
      end
   end

   assign secCtl.globalDebugOff = security_r[`PSR_SEC_GDBG_BIT];
   assign secCtl.jtagCfgBlock = security_r[`PSR_SEC_JTAGCFG_BIT];
   assign secCtl.debugTapOff = security_r[`PSR_SEC_TAP_BIT];
   assign secCtl.otpLockAll = security_r[`PSR_SEC_OTPALL_BIT];
   assign secCtl.otpSectorLock =
      security_r[`PSR_SEC_SECT_MSB:`PSR_SEC_SECT_LSB];
   assign secCtl.otpRedundancy = security_r[`PSR_SEC_REDUN_BIT];
   assign secCtl.bootFromOtp = security_r[`PSR_SEC_BOOTOTP_BIT];

   // ****************************************************************
   // Ring oscillators
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ringCtl_r <= `PSR_RINGCTL_RST;
      end
      else if (psReq.wr && psReq.num == `PSR_NUM_RINGCTL)
      begin
         ringCtl_r <= psReq.wdata & `PSR_RINGCTL_WMASK;
      end
   end

   // Tile cell and wire follow the core bit, the other two the periphery.
   assign oscEnable = {ringCtl_r[`PSR_RING_PERIPH_BIT],
                       ringCtl_r[`PSR_RING_PERIPH_BIT],
                       ringCtl_r[`PSR_RING_CORE_BIT],
                       ringCtl_r[`PSR_RING_CORE_BIT]};
   assign ringOscEn = oscEnable;

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_ring
         psr_ring_counter u_ring
         (
            .clk(clk),
            .rst_n(rst_n),
            .enable(oscEnable[i]),
            .oscIn(ringOscPin[i]),
            .count(ringCnt[i])
         );
         assign ringCount[i] = ringCnt[i];
      end
   endgenerate

   // ****************************************************************
   // Read data and answer
   // ****************************************************************
   always_comb
   begin
      rdata_nxt = '0;
      hit_nxt = 1'b1;
      if (psReq.num == `PSR_NUM_VECTOR)
      begin
         rdata_nxt = vectorBase_r;
      end
      else if (psReq.num == `PSR_NUM_TILECTL)
      begin
         rdata_nxt = tileCtl_r;
      end
      else if (psReq.num == `PSR_NUM_BOOT)
      begin
         rdata_nxt = bootStatus_r;
      end
      else if (psReq.num == `PSR_NUM_SECURITY)
      begin
         rdata_nxt = security_r;
      end
      else if (psReq.num == `PSR_NUM_RINGCTL)
      begin
         rdata_nxt = ringCtl_r;
      end
      else if (psReq.num == `PSR_NUM_RING_TCELL)
      begin
         rdata_nxt = {16'h0000, ringCnt[0]};
      end
      else if (psReq.num == `PSR_NUM_RING_TWIRE)
      begin
         rdata_nxt = {16'h0000, ringCnt[1]};
      end
      else if (psReq.num == `PSR_NUM_RING_PCELL)
      begin
         rdata_nxt = {16'h0000, ringCnt[2]};
      end
      else if (psReq.num == `PSR_NUM_RING_PWIRE)
      begin
         rdata_nxt = {16'h0000, ringCnt[3]};
      end
      else if (psReq.num == `PSR_NUM_RAMSIZE)
      begin
         rdata_nxt = `PSR_RAM_SIZE & `PSR_RAMSIZE_LOWMASK;
      end
      else
      begin
         hit_nxt = 1'b0;
      end
   end

   // Read-only numbers and unknown numbers answer with an error on write.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         psRsp_r <= '0;
      end
      else
      begin
         psRsp_r.valid <= psReq.rd || psReq.wr;
         psRsp_r.rdata <= psReq.rd ? rdata_nxt : 32'h0000_0000;
         psRsp_r.err <= (psReq.rd && !hit_nxt) || secRefused ||
            (psReq.wr && (!hit_nxt || psReq.num == `PSR_NUM_BOOT ||
             psReq.num == `PSR_NUM_RAMSIZE ||
             (psReq.num >= `PSR_NUM_RING_TCELL &&
              psReq.num <= `PSR_NUM_RING_PWIRE)));
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign psRsp = psRsp_r;
   assign vectorAddr = vectorAddr_r;
   assign vectorAddrValid = vectorAddrValid_r;
   assign rgmiiPortEn = tileCtl_r[`PSR_PORTEN_BIT];
   assign lowPowerDivOn = lowPowerDivOn_r;

endmodule

// File: rtl/psr_txclk_div.sv
// Purpose: Transmit clock divider and data launch delay.
// Assumes: clk is the PLL output that paces the interface.
// Notes: A divider value of zero holds the clock high.
`timescale 1ns/1ns
`include "psr_defs.svh"
module psr_txclk_div
   import psr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Settings
   input wire logic enable,
   input wire logic [`PSR_TXDIV_W-1:0] divVal,
   input wire logic [`PSR_TXDLY_W-1:0] dlyVal,
   // Outputs
   output logic txClk,
   output logic txLaunch
);

   logic [`PSR_TXDIV_W-1:0] cnt_r;
   logic [`PSR_TXDLY_W-1:0] dlyCnt_r;
   logic armed_r;
   logic txClk_r;
   logic txLaunch_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         txClk_r <= 1'b0;
      end
      else if (!enable)
      begin
         cnt_r <= '0;
         txClk_r <= 1'b0;
      end
      else
      begin
         cnt_r <= (cnt_r >= divVal) ? '0 : cnt_r + `PSR_TXDIV_W'(1);
         if (cnt_r == divVal)
         begin
            txClk_r <= 1'b1;
         end
         else if (cnt_r == (divVal >> 1))
         begin
            txClk_r <= 1'b0;
         end
      end
   end

   // Data launch trails each rising clock by one more PLL cycle than programmed.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dlyCnt_r <= '0;
         armed_r <= 1'b0;
         txLaunch_r <= 1'b0;
      end
      else
      begin
         txLaunch_r <= 1'b0;
         if (enable && cnt_r == divVal)
         begin
            dlyCnt_r <= '0;
            armed_r <= 1'b1;
         end
         else if (armed_r && dlyCnt_r == dlyVal)
         begin
            armed_r <= 1'b0;
            txLaunch_r <= 1'b1;
         end
         else if (armed_r)
         begin
            dlyCnt_r <= dlyCnt_r + `PSR_TXDLY_W'(1);
         end
      end
   end

   assign txClk = txClk_r;
   assign txLaunch = txLaunch_r;

endmodule

// File: sim/psr_status_regs_sva.sv
// Purpose: Port-level checks of the processor-status register bank.
// Assumes: Answers are registered one cycle after the taking edge.
// Notes: Bound to psr_status_regs from the testbench top file.
`timescale 1ns/1ns
module psr_status_regs_sva
   import psr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Status port
   input psr_req_t psReq,
   input psr_rsp_t psRsp,
   // Event and tile control
   input wire logic eventTake,
   input wire logic [15:0] eventVector,
   input wire logic [31:0] vectorAddr,
   input wire logic vectorAddrValid,
   input wire logic rgmiiTxClk,
   input wire logic rgmiiPortEn,
   input wire logic lowPowerDivOn,
   // Security and oscillators
   input wire logic otpSecValid,
   input psr_sec_t secCtl,
   input wire logic [3:0] ringOscEn
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] n);
      psReq.rd && psReq.num == n;
   endsequence
   sequence s_wr(logic [7:0] n);
      psReq.wr && psReq.num == n;
   endsequence
   property p_rsp_valid;
      psRsp.valid == ($past(psReq.rd) || $past(psReq.wr));
   endproperty
   a_rsp_valid: assert property (p_rsp_valid)
      else $error("answer strobe does not follow request");
   property p_rd_vec;
      s_rd(8'h01) |=> psRsp.rdata[17:0] == 18'h0 && !psRsp.err;
   endproperty
   a_rd_vec: assert property (p_rd_vec)
      else $error("vector base low bits not zero");
   property p_rd_ctl;
      s_rd(8'h02) |=> (psRsp.rdata & 32'hFC00_00CF) == 32'h0;
   endproperty
   a_rd_ctl: assert property (p_rd_ctl)
      else $error("tile control reserved bits not zero");
   property p_rd_ring;
      psReq.rd && psReq.num inside {[8'h07:8'h0A]}
         |=> psRsp.rdata[31:16] == 16'h0 && !psRsp.err;
   endproperty
   a_rd_ring: assert property (p_rd_ring)
      else $error("oscillator count upper half not zero");
   property p_rd_ram;
      s_rd(8'h0C) |=> psRsp.rdata[1:0] == 2'b00 && !psRsp.err;
   endproperty
   a_rd_ram: assert property (p_rd_ram)
      else $error("memory size low bits not zero");
   property p_wr_ro;
      psReq.wr && psReq.num inside {8'h03, [8'h07:8'h0A], 8'h0C}
         |=> psRsp.err && psRsp.rdata == 32'h0;
   endproperty
   a_wr_ro: assert property (p_wr_ro)
      else $error("write to read-only number not refused");
   property p_port_en;
      s_wr(8'h02) |=> rgmiiPortEn == $past(psReq.wdata[8]);
   endproperty
   a_port_en: assert property (p_port_en)
      else $error("port enable does not follow control write");
   property p_txclk_idle;
      !rgmiiPortEn [*3] |-> !rgmiiTxClk;
   endproperty
   a_txclk_idle: assert property (p_txclk_idle)
      else $error("transmit clock runs while ports disabled");
   property p_lowpow_off;
      s_wr(8'h02) ##0 !psReq.wdata[4] |=> ##1 !lowPowerDivOn;
   endproperty
   a_lowpow_off: assert property (p_lowpow_off)
      else $error("low-power divider on while disabled");
   property p_evt;
      eventTake |=> vectorAddrValid && vectorAddr[15:0] == $past(eventVector);
   endproperty
   a_evt: assert property (p_evt)
      else $error("vector address low half wrong");
   property p_sec_src;
      $changed(secCtl) |-> $past(otpSecValid) ||
         ($past(psReq.wr) && $past(psReq.num) == 8'h05);
   endproperty
   a_sec_src: assert property (p_sec_src)
      else $error("security bits changed without a load or write");
   property p_ring_pair;
      ringOscEn[1] == ringOscEn[0] && ringOscEn[3] == ringOscEn[2];
   endproperty
   a_ring_pair: assert property (p_ring_pair)
      else $error("oscillator enables not paired");
endmodule

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the processor-status register bank.
// Assumes: One request at a time, inputs driven at the falling edge.
// Notes: Oscillator deltas are checked once the counts are known.
`timescale 1ns/1ns
`include "psr_defs.svh"
module tb_top
   import psr_pkg::*;
;
   logic clk, rst_n, eventTake, vectorAddrValid, allThreadsPaused;
   logic rgmiiTxClk, rgmiiTxLaunch, rgmiiPortEn, lowPowerDivOn, otpSecValid;
   psr_req_t psReq;
   psr_rsp_t psRsp;
   psr_boot_t bootStrap;
   psr_sec_t secCtl;
   logic [15:0] eventVector;
   logic [31:0] vectorAddr, otpSecWord, q;
   logic [7:0] processorNumber;
   logic [1:0] bootPllModePin;
   logic [3:0] ringOscPin, ringOscEn;
   logic [15:0] ringCount [4];
   logic [31:0] base [4];
   logic [31:0] cnt [4];
   logic e;
   int mismatches, tests_run, hi, lo, dl, d0;
   psr_status_regs u_psr_status_regs (.clk(clk), .rst_n(rst_n),
      .psReq(psReq), .psRsp(psRsp), .eventTake(eventTake),
      .eventVector(eventVector), .vectorAddr(vectorAddr),
      .vectorAddrValid(vectorAddrValid), .allThreadsPaused(allThreadsPaused),
      .rgmiiTxClk(rgmiiTxClk), .rgmiiTxLaunch(rgmiiTxLaunch),
      .rgmiiPortEn(rgmiiPortEn), .lowPowerDivOn(lowPowerDivOn),
      .processorNumber(processorNumber), .bootPllModePin(bootPllModePin),
      .bootStrap(bootStrap), .otpSecValid(otpSecValid),
      .otpSecWord(otpSecWord), .secCtl(secCtl), .ringOscPin(ringOscPin),
      .ringOscEn(ringOscEn), .ringCount(ringCount));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] n,
      input logic [31:0] d, output logic [31:0] r, output logic er);
      @(negedge clk);
      psReq = '{rd: !w, wr: w, num: n, wdata: d};
      @(negedge clk);
      psReq = '0;
      chk({31'h0, psRsp.valid}, 32'h1);
      r = psRsp.rdata;
      er = psRsp.err;
   endtask
   task automatic rd(input logic [7:0] n, input logic [31:0] x,
      input logic xe);
      acc(1'b0, n, 32'h0, q, e);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wr(input logic [7:0] n, input logic [31:0] d,
      input logic xe);
      acc(1'b1, n, d, q, e);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic ctl(input logic [7:0] dly, input logic [8:0] dv,
      input logic dyn, input logic den);
      wr(8'h02, {6'h0, dly, dv, 1'b1, 2'b00, dyn, den, 4'h0}, 1'b0);
   endtask
   task automatic tx_measure();
      int k;
      k = 0;
      while (k < 40 && rgmiiTxClk !== 1'b0) begin @(negedge clk); k++; end
      while (k < 80 && rgmiiTxClk !== 1'b1) begin @(negedge clk); k++; end
      k = 0; hi = 0; lo = 0; dl = -1;
      while (k < 40 && !(lo > 0 && rgmiiTxClk === 1'b1))
      begin
         if (rgmiiTxLaunch === 1'b1 && dl < 0)
            dl = k;
         if (rgmiiTxClk === 1'b1)
            hi++;
         else
            lo++;
         k++;
         @(negedge clk);
      end
   endtask
   task automatic read_rings();
      for (int i = 0; i < 4; i++)
         acc(1'b0, 8'h07 + 8'(i), 32'h0, cnt[i], e);
   endtask
   task automatic stop_test();
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ************************************************************
   // Stimulus
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #2000000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      rst_n = 1'b0; psReq = '0; eventTake = 1'b0; eventVector = 16'h0;
      allThreadsPaused = 1'b0; otpSecValid = 1'b0; otpSecWord = 32'h0;
      processorNumber = 8'h5A; bootPllModePin = 2'b10; ringOscPin = 4'h0;
      bootStrap = '{bootOverride: 1, core1Off: 0, skipOtpPoll: 1,
         bootFromRam: 0, bootFromJtag: 1};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      rd(8'h01, 32'h0, 1'b0);
      rd(8'h02, 32'h0, 1'b0);
      rd(8'h06, 32'h0, 1'b0);
      rd(8'h03, 32'h005A_0116, 1'b0);
      processorNumber = 8'hA5;
      rd(8'h03, 32'h005A_0116, 1'b0);
      wr(8'h01, 32'hFFFF_FFFF, 1'b0);
      rd(8'h01, 32'hFFFC_0000, 1'b0);
      wr(8'h02, 32'hFFFF_FFFF, 1'b0);
      rd(8'h02, 32'h03FF_FF30, 1'b0);
      wr(8'h06, 32'hFFFF_FFFF, 1'b0);
      rd(8'h06, 32'h0000_0003, 1'b0);
      foreach (base[i]) wr(8'h07 + 8'(i), 32'hFFFF_FFFF, 1'b1);
      wr(8'h03, 32'h0, 1'b1);
      wr(8'h0C, 32'h0, 1'b1);
      wr(8'h04, 32'h0, 1'b1);
      rd(8'h04, 32'h0, 1'b1);
      rd(8'h0C, `PSR_RAM_SIZE, 1'b0);
      wr(8'h01, 32'hABCC_0000, 1'b0);
      eventTake = 1'b1;
      eventVector = 16'h1234;
      @(negedge clk);
      eventTake = 1'b0;
      chk({31'h0, vectorAddrValid}, 32'h1);
      chk(vectorAddr, 32'hABCC_1234);
      ctl(8'h00, 9'd4, 1'b0, 1'b0);
      chk({31'h0, rgmiiPortEn}, 32'h1);
      tx_measure();
      chk(hi, 3);
      chk(lo, 2);
      d0 = dl;
      ctl(8'h03, 9'd4, 1'b0, 1'b0);
      tx_measure();
      chk(dl - d0, 3);
      for (int i = 0; i < 4; i++)
      begin
         ctl(8'h00, 9'd4, i[1], 1'b1);
         allThreadsPaused = i[0];
         repeat (3) @(negedge clk);
         chk({31'h0, lowPowerDivOn}, {31'h0, !i[1] || i[0]});
      end
      ctl(8'h00, 9'd4, 1'b0, 1'b0);
      repeat (3) @(negedge clk);
      chk({31'h0, lowPowerDivOn}, 32'h0);
      otpSecValid = 1'b1;
      otpSecWord = 32'h7FFF_FFFF;
      @(negedge clk);
      otpSecValid = 1'b0;
      rd(8'h05, 32'h0000_5FB1, 1'b0);
      chk({22'h0, secCtl}, 32'h0000_03FF);
      wr(8'h05, 32'h8000_4011, 1'b0);
      rd(8'h05, 32'h8000_4011, 1'b0);
      chk({22'h0, secCtl}, 32'h0000_0380);
      wr(8'h05, 32'h0000_1FA0, 1'b1);
      rd(8'h05, 32'h8000_4011, 1'b0);
      read_rings();
      base = cnt;
      wr(8'h06, 32'h1, 1'b0);
      @(negedge clk);
      chk({28'h0, ringOscEn}, 32'hC);
      wr(8'h06, 32'h2, 1'b0);
      @(negedge clk);
      chk({28'h0, ringOscEn}, 32'h3);
      wr(8'h06, 32'h0, 1'b0);
      read_rings();
      base = cnt;
      wr(8'h06, 32'h3, 1'b0);
      for (int j = 0; j < 4; j++)
      begin
         ringOscPin = 4'hF << j;
         repeat (4) @(negedge clk);
         ringOscPin = 4'h0;
         repeat (4) @(negedge clk);
      end
      wr(8'h06, 32'h0, 1'b0);
      repeat (10) @(negedge clk);
      read_rings();
      foreach (cnt[i])
         chk(cnt[i] - base[i], 32'(i + 1));
      base = cnt;
      bootStrap = '{bootOverride: 0, core1Off: 1, skipOtpPoll: 0,
         bootFromRam: 1, bootFromJtag: 0};
      bootPllModePin = 2'b01;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      read_rings();
      foreach (cnt[i]) chk(cnt[i], base[i]);
      rd(8'h03, 32'h00A5_0029, 1'b0);
      stop_test();
   end
endmodule
bind psr_status_regs psr_status_regs_sva u_psr_status_regs_sva (.clk(clk),
   .rst_n(rst_n), .psReq(psReq), .psRsp(psRsp), .eventTake(eventTake),
   .eventVector(eventVector), .vectorAddr(vectorAddr),
   .vectorAddrValid(vectorAddrValid), .rgmiiTxClk(rgmiiTxClk),
   .rgmiiPortEn(rgmiiPortEn), .lowPowerDivOn(lowPowerDivOn),
   .otpSecValid(otpSecValid), .secCtl(secCtl), .ringOscEn(ringOscEn));
